// >>> design/tts_addr_decode.sv
// Address decoder for the special register window.
// Assumes a word-aligned byte address from an APB slave.
`timescale 1ns/100ps
module tts_addr_decode
    import tts_pkg::*;
(
    // Address in
    input  wire logic [15:0] addr,
    // Decode out
    output      logic [2:0]  reg_index,
    output      logic        hit
);

    // Map each special address except the write pointer to its register index
    always_comb begin
        reg_index = 3'h0;
        hit       = 1'b1;
        case (addr)
            TTS_OFS_TRACK0:  reg_index = 3'h0;
            TTS_OFS_TRACK1:  reg_index = 3'h1;
            TTS_OFS_TRACK2:  reg_index = 3'h2;
            TTS_OFS_TRACK3:  reg_index = 3'h3;
            TTS_OFS_TRACK4:  reg_index = 3'h4;
            TTS_OFS_MQ_READ: reg_index = 3'h5;
            default:         hit       = 1'b0;
        endcase
    end

endmodule : tts_addr_decode

// >>> design/tts_pkg.sv
// Constants for the touch tracker status register bank.
// Assumes a 32-bit APB slave at 100 MHz pclk, asynchronous active-low reset.
package tts_pkg;

    // Byte addresses of the special register window
    localparam logic [15:0] TTS_OFS_TRACK0    = 16'h7000;
    localparam logic [15:0] TTS_OFS_TRACK1    = 16'h7004;
    localparam logic [15:0] TTS_OFS_TRACK2    = 16'h7008;
    localparam logic [15:0] TTS_OFS_TRACK3    = 16'h700C;
    localparam logic [15:0] TTS_OFS_TRACK4    = 16'h7010;
    localparam logic [15:0] TTS_OFS_MQ_READ   = 16'h7014;
    localparam logic [15:0] TTS_OFS_MQ_WRITE  = 16'h7018;

    // Field layout of a tracker word
    localparam int          TTS_VAL_LSB       = 16;
    localparam int          TTS_VAL_W         = 16;
    localparam int          TTS_TAG_LSB       = 0;
    localparam int          TTS_TAG_W         = 8;
    localparam int          TTS_POINTS        = 5;

    // Reset values
    localparam logic [31:0] TTS_RST_TRACK     = 32'h0000_0000;
    localparam logic [31:0] TTS_RST_MQ_READ   = 32'h0000_0000;

endpackage : tts_pkg

// >>> design/tts_status_regs.sv
// Touch tracker status register bank with APB slave port.
// Assumes coprocessor and touch engine drive update strobes synchronous to pclk.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module tts_status_regs
    import tts_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Tracker updates from the coprocessor
    input  wire logic [4:0]  track_update,
    input  wire logic [15:0] track_value [TTS_POINTS],
    input  wire logic [7:0]  track_tag   [TTS_POINTS],
    // Touch engine mode
    input  wire logic        capacitive_touch_engine_extended,
    // Media queue read pointer from the consumer
    input  wire logic        mq_read_update,
    input  wire logic [31:0] mq_read_addr
);

    typedef enum logic [1:0] {
        TTS_IDLE   = 2'b00,
        TTS_ANSWER = 2'b01
    } tts_state_t;

    tts_state_t  state;
    tts_state_t  next_state;
    logic [31:0] track      [TTS_POINTS];
    logic [31:0] next_track [TTS_POINTS];
    logic [31:0] media_queue_read_ptr;
    logic [31:0] next_media_queue_read_ptr;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [2:0]  reg_index;
    logic        hit;

    // Pack value and tag into a tracker word, reserved bits zero
    function automatic logic [31:0] tts_pack(input logic [15:0] val, input logic [7:0] tag);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[TTS_VAL_LSB +: TTS_VAL_W] = val;
        w[TTS_TAG_LSB +: TTS_TAG_W] = tag;
        return w;
    endfunction : tts_pack

    // Point 0 always live; points 1-4 only in extended mode
    function automatic logic tts_point_live(input logic [2:0] idx, input logic ext);
        return (idx == 3'h0) || ext;
    endfunction : tts_point_live

    tts_addr_decode u_decode (
        .addr      (paddr),
        .reg_index (reg_index),
        .hit       (hit)
    );

    // Status storage; only hardware updates it, bus writes never reach it
    always_comb begin
        for (int i = 0; i < TTS_POINTS; i++) begin
            next_track[i] = track[i];
            if (track_update[i]) begin
                if (tts_point_live(3'(i), capacitive_touch_engine_extended)) begin
                    next_track[i] = tts_pack(track_value[i], track_tag[i]);
                end
            end
        end
        next_media_queue_read_ptr = media_queue_read_ptr;
        if (mq_read_update) begin
            next_media_queue_read_ptr = mq_read_addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < TTS_POINTS; i++) begin
                track[i] <= TTS_RST_TRACK;
            end
            media_queue_read_ptr <= TTS_RST_MQ_READ;
        end else begin
            track                <= next_track;
            media_queue_read_ptr <= next_media_queue_read_ptr;
        end
    end

    // APB answer: one wait state, registered outputs
    always_comb begin
        next_state   = state;
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        case (state)
            TTS_IDLE: begin
                if (psel && !penable) begin
                    next_state = TTS_ANSWER;
                end
            end
            TTS_ANSWER: begin
                if (pready) begin
                    // Access ends here; error flag must not outlive ready
                    next_state = TTS_IDLE;
                end else if (psel && penable) begin
                    next_pready  = 1'b1;
                    // Write pointer address is not ours: answered as unmapped
                    next_pslverr = !hit;
                    next_prdata  = 32'h0000_0000;
                    // Writes complete with no effect on storage
                    if (!pwrite && hit) begin
                        if (reg_index == 3'h5) begin
                            next_prdata = media_queue_read_ptr;
                        end else if (tts_point_live(reg_index, capacitive_touch_engine_extended)) begin
                            next_prdata = track[reg_index];
                        end
                    end
                end
            end
            default: next_state = TTS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= TTS_IDLE;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state   <= next_state;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule : tts_status_regs

// >>> dv/tb_touch_tracker_status_regs.sv
// Bench: reset values, updates, ignored writes, mode gating.
`timescale 1ns/100ps
module tb_touch_tracker_status_regs;
    import tts_pkg::*;
    logic pclk = 0, presetn = 0, pready, pslverr, psel, penable, pwrite, err, ext = 1, mq_upd = 0;
    logic [15:0] paddr, val [TTS_POINTS] = '{default: '0};
    logic [31:0] pwdata, prdata, rd, mq_addr = '0;
    logic [7:0]  tag [TTS_POINTS] = '{default: '0};
    logic [4:0]  upd = '0;
    bit          to;
    int          mismatches, n_checks;
    tts_status_regs uut (.*, .pstrb(4'hF), .track_update(upd), .track_value(val), .track_tag(tag),
        .capacitive_touch_engine_extended(ext), .mq_read_update(mq_upd), .mq_read_addr(mq_addr));
    tts_host host (.*);
    initial forever #5 pclk = ~pclk;
    function automatic logic [15:0] adr(int i); return 16'h7000 + 16'(4 * i); endfunction
    function automatic logic [31:0] xv(int i);
        return i == 5 ? 32'h0001_2340 : {16'hA000 + 16'(i), 8'h00, 8'h10 + 8'(i)};
    endfunction
    task automatic final_report;
        if (mismatches == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic chk(input int i, input logic [31:0] x, input logic xe);
        host.xfer(1'b0, adr(i), '0, rd, err, to);
        n_checks++;
        if (to || rd !== x || err !== xe) begin
            mismatches++;
            $display("BAD reg %h exp %h %b got %h %b", adr(i), x, xe, rd, err);
        end
        if (to) final_report();
    endtask : chk
    task automatic wr(input int i, input logic xe);
        host.xfer(1'b1, adr(i), 32'hFFFF_FFFF, rd, err, to);
        n_checks++;
        if (to || err !== xe) begin
            mismatches++;
            $display("BAD wr %h err exp %b got %b", adr(i), xe, err);
        end
        if (to) final_report();
    endtask : wr
    task automatic put(input int i, input logic [15:0] v);
        @(posedge pclk);
        {val[i], tag[i], upd} <= {v, 8'h10 + 8'(i), 5'(1 << i)};
        @(posedge pclk);
        upd <= '0;
    endtask : put
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) chk(i, '0, 0);
        for (int i = 0; i < 5; i++) put(i, 16'hA000 + 16'(i));
        {mq_addr, mq_upd} <= {32'h0001_2340, 1'b1};
        @(posedge pclk);
        mq_upd <= 1'b0;
        for (int i = 0; i < 6; i++) chk(i, xv(i), 0);
        for (int i = 0; i < 6; i++) wr(i, 1'b0);
        for (int i = 0; i < 6; i++) chk(i, xv(i), 0);
        wr(6, 1'b1);
        chk(6, '0, 1);
        chk(-1, '0, 1);
        ext <= 1'b0;
        put(2, 16'h5555);
        for (int i = 0; i < 5; i++) chk(i, i ? '0 : xv(0), 0);
        ext <= 1'b1;
        chk(2, xv(2), 0);
        final_report();
    end
endmodule : tb_touch_tracker_status_regs
bind tts_status_regs tts_mon mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr,
    .prdata, .mq_read_addr, .track_update, .track_value, .track_tag, .capacitive_touch_engine_extended,
    .mq_read_update);

// >>> dv/tts_host.sv
// Host model: APB master for the status bank.
// Assumes the slave ends each access with pready; every wait is bounded.
`timescale 1ns/100ps
module tts_host (
    input  wire logic        pclk, pready, pslverr,
    input  wire logic [31:0] prdata,
    output      logic        psel, penable, pwrite,
    output      logic [15:0] paddr,
    output      logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // One transfer, held until pready; to flags a hang
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output bit to);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Answer taken at the rising edge that samples pready high
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        r  = prdata;
        e  = pslverr;
        to = (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : xfer
endmodule : tts_host

// >>> dv/tts_monitor.sv
// Checker for the status bank bus port and register contents.
// Assumes a bind to tts_status_regs.
`timescale 1ns/100ps
module tts_mon
    import tts_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata, mq_read_addr,
    input wire logic [4:0]  track_update,
    input wire logic [15:0] track_value [TTS_POINTS],
    input wire logic [7:0]  track_tag   [TTS_POINTS],
    input wire logic        capacitive_touch_engine_extended, mq_read_update
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] m [6];
    wire         ext = capacitive_touch_engine_extended;
    wire         hit = paddr >= TTS_OFS_TRACK0 && paddr <= TTS_OFS_MQ_READ && paddr[1:0] == 2'h0;
    wire  [2:0]  ix  = paddr[4:2];
    // Expected contents; points 1-4 frozen outside extended mode
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) m <= '{default: '0};
        else for (int i = 0; i < 6; i++)
            if (i == 5 ? mq_read_update : track_update[i] && (i == 0 || ext))
                m[i] <= i == 5 ? mq_read_addr : {track_value[i], 8'h00, track_tag[i]};
    a_wait_state: assert property (psel && !penable |-> ##2 pready) else $error("late ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_bad_addr: assert property (pready && !hit |-> pslverr && prdata == '0) else $error("no refusal");
    a_good_addr: assert property (pready && hit |-> !pslverr) else $error("mapped refused");
    a_rsvd_zero: assert property (pready && !pwrite && hit && ix < 5 |-> prdata[15:8] == 8'h00)
        else $error("reserved set");
    a_read_match: assert property (pready && !pwrite && hit && (ix == 0 || ix == 5 || ext) |-> prdata == m[ix])
        else $error("read wrong");
    a_mode_gate: assert property (pready && !pwrite && hit && ix != 0 && ix < 5 && !ext |-> prdata == '0)
        else $error("gate open");
    c_read: cover property (pready && !pwrite && hit && ix == 5);
    c_err: cover property (pready && pslverr);
    c_gate: cover property (pready && !ext && ix == 2);
endmodule : tts_mon
